//--- ptp_message_mode_config.sv
// ptp message mode configuration register and its mode outputs
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ptp_message_mode_config
	import ptp_msg_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                          clk_sys_in,
	input  wire logic                          rst_in,
	// register port
	input  wire logic [ptp_msg_cfg_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [ptp_msg_cfg_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                          wr_in,
	input  wire logic                          rd_in,
	output logic      [ptp_msg_cfg_pkg::DATA_W-1:0] rdata_out,
	// mode controls to the ptp datapath
	output logic                               ptp_mode_out,
	output logic                               ptp_clk_en_out,
	output logic                               classify_en_out,
	output logic                               tail_tag_ts_out,
	output logic                               bridge_mode_out,
	output logic                               fwd_all_host_out,
	output logic                               hdr_rewrite_en_out,
	output logic                               ts_insert_en_out,
	output logic                               det_eth_out,
	output logic                               det_ipv4_out,
	output logic                               det_ipv6_out,
	output logic                               p2p_out,
	output logic                               host_master_out,
	output logic                               one_step_out
);
	import ptp_msg_cfg_pkg::*;

	logic [CFG_W-1:0] cfg_q;
	logic             ptp_on;
	logic             bridge_on;
	logic             rewrite_on;

	function automatic logic hit(input logic [ADDR_W-1:0] a);
		return a == CFG_OFFSET;
	endfunction

	// only the low byte is stored; upper byte writes are dropped
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= CFG_RESET;                          // [R8] [R9] [R10] [R11] [R12] [R13]
		end else if (wr_in && hit(addr_in)) begin
			cfg_q <= wdata_in[CFG_W-1:0];                // [R14]
		end
	end

	// read data stand one cycle after the strobe and only then
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in && hit(addr_in)) begin
			rdata_out <= {8'h00, cfg_q};                  // [R14]
		end else begin
			rdata_out <= 16'h0000;                        // unmapped reads give zero
		end
	end

	ptp_cfg_decode u_decode (
		.cfg_in         (cfg_q),
		.ptp_on_out     (ptp_on),
		.bridge_on_out  (bridge_on),
		.rewrite_on_out (rewrite_on)
	);

	// outputs registered from the decode so each leaves a flip-flop;
	// costs one cycle of lag after a write, harmless for static config
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ptp_mode_out       <= 1'b0;
			ptp_clk_en_out     <= 1'b0;
			classify_en_out    <= 1'b0;
			tail_tag_ts_out    <= 1'b0;
			bridge_mode_out    <= 1'b0;
			fwd_all_host_out   <= 1'b0;
			hdr_rewrite_en_out <= 1'b0;
			ts_insert_en_out   <= 1'b0;
		end else begin
			ptp_mode_out       <= ptp_on;
			ptp_clk_en_out     <= ptp_on;               // [R6]
			classify_en_out    <= ptp_on;               // [R4]
			tail_tag_ts_out    <= ptp_on;               // [R7]
			bridge_mode_out    <= bridge_on;            // [R1]
			fwd_all_host_out   <= bridge_on;            // [R2]
			hdr_rewrite_en_out <= rewrite_on;           // [R3] [R5]
			ts_insert_en_out   <= ptp_on;               // [R5]
		end
	end

	// encapsulation and clock-role selects
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			det_eth_out     <= CFG_RESET[BIT_DET_ETH];
			det_ipv4_out    <= CFG_RESET[BIT_DET_IP4];
			det_ipv6_out    <= CFG_RESET[BIT_DET_IP6];
			p2p_out         <= CFG_RESET[BIT_P2P];
			host_master_out <= CFG_RESET[BIT_MASTER];
			one_step_out    <= CFG_RESET[BIT_ONE_STEP];
		end else begin
			det_eth_out     <= cfg_q[BIT_DET_ETH];      // [R8]
			det_ipv4_out    <= cfg_q[BIT_DET_IP4];      // [R9]
			det_ipv6_out    <= cfg_q[BIT_DET_IP6];      // [R10]
			p2p_out         <= cfg_q[BIT_P2P];          // [R11]
			host_master_out <= cfg_q[BIT_MASTER];       // [R12]
			one_step_out    <= cfg_q[BIT_ONE_STEP];     // [R13]
		end
	end
endmodule

//--- ptp_msg_cfg_pkg.sv
// constants for the ptp message mode configuration register
// Function
// [R1] bridging-mode bit 7 acts only while general ptp mode bit 6 is set.
// [R2] with bridging and ptp mode on, every ptp message goes to the host port.
// [R3] with bridging mode in effect, ptp headers pass through unaltered.
// [R4] ptp mode bit 6 makes frames classified by ptp type with special forwarding.
// [R5] with ptp mode on, headers may be rewritten and timestamps inserted.
// [R6] ptp mode bit switches the internal ptp clock on; clear leaves it off.
// [R7] with ptp mode on, the host tail tag carries timestamp information.
// [R8] bit 5 enables detection of ptp over raw ethernet; reset value one.
// [R9] bit 4 enables detection of ptp over ipv4/udp; reset value one.
// [R10] bit 3 enables detection of ptp over ipv6/udp; reset value one.
// [R11] bit 2 selects peer-to-peer (1) or end-to-end (0); reset zero.
// [R12] bit 1 makes host port master (1) or slave (0); reset zero.
// [R13] bit 0 selects one-step (1) or two-step (0); reset one.
// [R14] upper byte reads zero and writes there have no effect.
package ptp_msg_cfg_pkg;
	localparam int          ADDR_W       = 16;
	localparam int          DATA_W       = 16;
	localparam int          CFG_W        = 8;
	localparam logic [15:0] CFG_OFFSET   = 16'h0514;
	localparam int          BIT_BRIDGE   = 7;
	localparam int          BIT_PTP      = 6;
	localparam int          BIT_DET_ETH  = 5;
	localparam int          BIT_DET_IP4  = 4;
	localparam int          BIT_DET_IP6  = 3;
	localparam int          BIT_P2P      = 2;
	localparam int          BIT_MASTER   = 1;
	localparam int          BIT_ONE_STEP = 0;
	localparam logic [7:0]  CFG_RESET    = 8'h39;
endpackage

//--- ptp_cfg_decode.sv
// decodes stored configuration bits into effective mode controls
`timescale 1ns/1ps
module ptp_cfg_decode
	import ptp_msg_cfg_pkg::*;
(
	// stored configuration
	input  wire logic [CFG_W-1:0] cfg_in,
	// effective controls
	output logic                  ptp_on_out,
	output logic                  bridge_on_out,
	output logic                  rewrite_on_out
);
	// bridging only counts under ptp mode, and then freezes headers
	always_comb begin
		ptp_on_out     = cfg_in[BIT_PTP];                       // [R4]
		bridge_on_out  = cfg_in[BIT_BRIDGE] & cfg_in[BIT_PTP];  // [R1]
		rewrite_on_out = cfg_in[BIT_PTP] & ~bridge_on_out;     // [R3] [R5]
	end
endmodule

//--- ptp_cfg_assertions.sv
// port assertions for the ptp message mode register
`timescale 1ns/1ps
module ptp_cfg_chk
	import ptp_msg_cfg_pkg::*;
(
	// all ports of the register block
	input wire logic        clk_sys_in, rst_in, wr_in, rd_in,
	input wire logic [15:0] addr_in, wdata_in, rdata_out,
	input wire logic        ptp_mode_out, ptp_clk_en_out, classify_en_out,
	input wire logic        tail_tag_ts_out, bridge_mode_out, fwd_all_host_out,
	input wire logic        hdr_rewrite_en_out, ts_insert_en_out, det_eth_out,
	input wire logic        det_ipv4_out, det_ipv6_out, p2p_out,
	input wire logic        host_master_out, one_step_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// derived controls must track the stored mode bits in every cycle
	property p_br; bridge_mode_out |-> ptp_mode_out; endproperty
	a_br: assert property (p_br) else $error("bridge w/o ptp");
	property p_fwd; fwd_all_host_out == bridge_mode_out; endproperty
	a_fwd: assert property (p_fwd) else $error("fwd all");
	property p_hdr; hdr_rewrite_en_out == (ptp_mode_out && !bridge_mode_out);
	endproperty
	a_hdr: assert property (p_hdr) else $error("hdr rewrite");
	property p_cls; classify_en_out == ptp_mode_out; endproperty
	a_cls: assert property (p_cls) else $error("classify");
	property p_ts; ts_insert_en_out == ptp_mode_out; endproperty
	a_ts: assert property (p_ts) else $error("ts insert");
	property p_clk; ptp_clk_en_out == ptp_mode_out; endproperty
	a_clk: assert property (p_clk) else $error("ptp clock");
	property p_tag; tail_tag_ts_out == ptp_mode_out; endproperty
	a_tag: assert property (p_tag) else $error("tail tag");
	// a write lands on the outputs two edges later, reserved byte dropped
	property p_wr; wr_in && addr_in == CFG_OFFSET |-> ##2
		{bridge_mode_out, ptp_mode_out, det_eth_out, det_ipv4_out, det_ipv6_out,
		p2p_out, host_master_out, one_step_out} ==
		$past({wdata_in[7] & wdata_in[6], wdata_in[6:0]}, 2); endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_rd; rd_in |=> rdata_out[15:8] == 8'h00; endproperty
	a_rd: assert property (p_rd) else $error("upper byte");
	// read data stand only in the cycle after a read strobe
	property p_rdz; !rd_in |=> rdata_out == 16'h0000; endproperty
	a_rdz: assert property (p_rdz) else $error("stale read data");
endmodule

//--- ptp_message_mode_config_test.sv
// self-checking bench for the ptp message mode register
`timescale 1ns/1ps
module ptp_message_mode_config_test;
	import ptp_msg_cfg_pkg::*;
	logic        clk_sys_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
	logic [15:0] addr_in = 0, wdata_in = 0, rdata_out, d;
	logic        ptp_mode_out, ptp_clk_en_out, classify_en_out, tail_tag_ts_out;
	logic        bridge_mode_out, fwd_all_host_out, hdr_rewrite_en_out;
	logic        ts_insert_en_out, det_eth_out, det_ipv4_out, det_ipv6_out;
	logic        p2p_out, host_master_out, one_step_out;
	int          fails = 0, n_compared = 0, seed = 76995;
	wire  [15:0] mode_w = {2'b00, ptp_mode_out, ptp_clk_en_out, classify_en_out,
		tail_tag_ts_out, ts_insert_en_out, bridge_mode_out, fwd_all_host_out,
		hdr_rewrite_en_out, det_eth_out, det_ipv4_out, det_ipv6_out, p2p_out,
		host_master_out, one_step_out};
	ptp_message_mode_config i_dut (.*);
	always #5 clk_sys_in = ~clk_sys_in;
	// expected mode outputs for a stored byte, in mode_w order
	function automatic logic [15:0] mo(logic [7:0] c);
		return {2'b00, {5{c[6]}}, {2{c[7] & c[6]}}, c[6] & ~c[7], c[5:0]};
	endfunction
	task automatic chk(logic [15:0] g, logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one-cycle strobe, then read data stand until the next edge
	task automatic acc(logic w, logic [15:0] a, logic [15:0] v);
		@(posedge clk_sys_in);
		wr_in <= w;
		rd_in <= !w;
		addr_in <= a;
		wdata_in <= v;
		@(posedge clk_sys_in);
		wr_in <= 0;
		rd_in <= 0;
		#1;
	endtask
	task automatic rdc(logic [7:0] c);
		acc(0, CFG_OFFSET, 16'h0000);
		chk(rdata_out, {8'h00, c});
		chk(mode_w, mo(c));
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 0;
		rdc(CFG_RESET);
		acc(1, 16'h0516, 16'h00C6);
		rdc(CFG_RESET);
		acc(0, 16'h0516, 16'h0000);
		chk(rdata_out, 16'h0000);
		$display("reset and unmapped test done");
		// corners first: bit 7 alone, both modes, all ones
		for (int i = 0; i < 44; i++) begin
			d = i == 0 ? 16'hFF80 : i == 1 ? 16'h00C0 : i == 2 ? 16'hFFFF
				: 16'($random(seed));
			acc(1, CFG_OFFSET, d);
			rdc(d[7:0]);
		end
		$display("write and read test done");
		// a reset in mid-run must bring back every documented default
		acc(1, CFG_OFFSET, 16'h00C6);
		@(posedge clk_sys_in);
		rst_in <= 1;
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 0;
		rdc(CFG_RESET);
		$display("mid-run reset test done");
		stop_test;
	end
endmodule
bind ptp_message_mode_config ptp_cfg_chk i_chk (.*);
